// file: core/sfcd_defs.vh
// constants for the serial flash command decoder
// assumes single-bit serial link, mode 0 or mode 3
// How it works
// - opcode 02 plus three address bytes then data programs that page
// - opcode 20 plus three address bytes erases the 4K sector
// - opcode d8 plus three address bytes erases the 64KB block
// - opcode 05 shifts out the status register
// - opcode 15 shifts out config register one then two
// - opcode 75 or b0 suspends a running program or erase
// - write-type commands rejected unless chip select rises on a byte boundary
// - program and erase need the write-enable latch set
// - inputs sampled on rising serial clock, outputs driven on falling edge
`ifndef SFCD_DEFS_VH
`define SFCD_DEFS_VH
`define SFCD_OP_READ 8'h03
`define SFCD_OP_FAST_READ 8'h0b
`define SFCD_OP_PAGE_PROGRAM 8'h02
`define SFCD_OP_SECTOR_ERASE 8'h20
`define SFCD_OP_BLOCK_ERASE 8'hd8
`define SFCD_OP_STATUS_READ 8'h05
`define SFCD_OP_CONFIG_READ 8'h15
`define SFCD_OP_SUSPEND_A 8'h75
`define SFCD_OP_SUSPEND_B 8'hb0
`define SFCD_OP_WRITE_ENABLE 8'h06
`define SFCD_OP_WRITE_DISABLE 8'h04
`define SFCD_SECTOR_MASK 24'hfff000
`define SFCD_BLOCK_MASK 24'hff0000
`define SFCD_PAGE_MASK 24'hffff00
`define SFCD_KIND_PROGRAM 2'h0
`define SFCD_KIND_SECTOR 2'h1
`define SFCD_KIND_BLOCK 2'h2
`define SFCD_STAT_BUSY 0
`define SFCD_STAT_LATCH 1
`define SFCD_FIFO_DEPTH 8
`endif

// file: core/sfcd_fifo.v
// small synchronous fifo for program data bytes
// assumes one clock; sink may stall to apply back-pressure
`timescale 1ns/1ps
module sfcd_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 8,
    parameter AW = 3
) (
    // system
    input wire clock,
    input wire srst,
    input wire flush,
    // fill side
    input wire in_valid,
    output wire in_ready,
    input wire [WIDTH-1:0] in_data,
    // drain side
    output wire out_valid,
    input wire out_ready,
    output wire [WIDTH-1:0] out_data
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0] wr_q;
    reg [AW-1:0] rd_q;
    reg [AW:0] cnt_q;
    wire push = in_valid && in_ready;
    wire pop = out_valid && out_ready;
    assign in_ready = (cnt_q != DEPTH[AW:0]);
    assign out_valid = (cnt_q != {(AW+1){1'b0}});
    assign out_data = mem[rd_q];
    always @(posedge clock) begin
        if (push)
            mem[wr_q] <= in_data;
    end
    always @(posedge clock) begin
        if (srst || flush) begin
            wr_q <= {AW{1'b0}};
            rd_q <= {AW{1'b0}};
            cnt_q <= {(AW+1){1'b0}};
        end else begin
            if (push)
                wr_q <= (wr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_q + 1'b1;
            if (pop)
                rd_q <= (rd_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_q + 1'b1;
            if (push && !pop)
                cnt_q <= cnt_q + 1'b1;
            else if (pop && !push)
                cnt_q <= cnt_q - 1'b1;
        end
    end
endmodule // sfcd_fifo

// file: core/sfcd_decoder.v
// serial flash command decoder: shifts in opcode and address, launches array work
// assumes link pins are asynchronous and oversampled by clock (link clock 160 ns)
`timescale 1ns/1ps
`include "sfcd_defs.vh"
module sfcd_decoder #(
    parameter DUMMY_BITS = 8
) (
    // system
    input wire clock,
    input wire srst,
    // serial link
    input wire sclk,
    input wire cs_n,
    input wire si,
    output reg so_q,
    output reg so_oe_q,
    // array side status and configuration
    input wire array_busy,
    input wire [7:0] status_bits,
    input wire [7:0] config1,
    input wire [7:0] config2,
    // array operation launch
    output reg op_start_q,
    output reg [1:0] op_kind_q,
    output reg [23:0] op_addr_q,
    output reg op_suspend_q,
    output reg write_enable_latch_q,
    // read address to the array
    output reg rd_req_q,
    output reg [23:0] rd_addr_q,
    input wire [7:0] rd_data,
    // program data stream
    output reg pgm_valid_q,
    output reg [7:0] pgm_data_q,
    input wire pgm_ready
);
    // two-stage synchronisers
    reg sclk_m_q, sclk_s_q, sclk_p_q;
    reg cs_m_q, cs_s_q;
    reg si_m_q, si_s_q;
    always @(posedge clock) begin
        sclk_m_q <= sclk;
        sclk_s_q <= sclk_m_q;
        sclk_p_q <= sclk_s_q;
        cs_m_q <= cs_n;
        cs_s_q <= cs_m_q;
        si_m_q <= si;
        si_s_q <= si_m_q;
    end
    wire sck_rise = sclk_s_q && !sclk_p_q;
    wire sck_fall = !sclk_s_q && sclk_p_q;
    wire selected = !cs_s_q;

    localparam ST_OP = 7'h01;
    localparam ST_ADDR = 7'h02;
    localparam ST_DUMMY = 7'h04;
    localparam ST_DATA_OUT = 7'h08;
    localparam ST_DATA_IN = 7'h10;
    localparam ST_TAIL = 7'h20;
    localparam ST_IGNORE = 7'h40;

    reg [6:0] st_q;
    reg [7:0] sh_q;
    reg [2:0] bit_q;
    reg [1:0] abyte_q;
    reg [7:0] op_q;
    reg [23:0] addr_q;
    reg [7:0] dcnt_q;
    reg [7:0] out_q;
    reg out_sel_q;
    reg was_sel_q;
    reg boundary_q;

    // program data buffered; fifo fill stalls only by dropping excess bytes
    // one more byte can wait in the output stage after the fifo
    wire fifo_in_ready;
    wire fifo_out_valid;
    wire [7:0] fifo_out_data;
    reg fifo_push_q;
    reg [7:0] fifo_byte_q;
    reg fifo_flush_q;
    sfcd_fifo #(.WIDTH(8), .DEPTH(`SFCD_FIFO_DEPTH), .AW(3)) u_fifo (
        .clock(clock),
        .srst(srst),
        .flush(fifo_flush_q),
        .in_valid(fifo_push_q),
        .in_ready(fifo_in_ready),
        .in_data(fifo_byte_q),
        .out_valid(fifo_out_valid),
        .out_ready(!pgm_valid_q || pgm_ready),
        .out_data(fifo_out_data)
    );

    function is_read_op;
        input [7:0] op;
        begin
            is_read_op = (op == `SFCD_OP_READ) || (op == `SFCD_OP_FAST_READ);
        end
    endfunction

    function is_addr_op;
        input [7:0] op;
        begin
            is_addr_op = is_read_op(op) || (op == `SFCD_OP_PAGE_PROGRAM) ||
                (op == `SFCD_OP_SECTOR_ERASE) || (op == `SFCD_OP_BLOCK_ERASE);
        end
    endfunction

    wire [7:0] sh_next = {sh_q[6:0], si_s_q};

    always @(posedge clock) begin
        if (srst) begin
            st_q <= ST_OP;
            sh_q <= 8'h00;
            bit_q <= 3'h0;
            abyte_q <= 2'h0;
            op_q <= 8'h00;
            addr_q <= 24'h000000;
            dcnt_q <= 8'h00;
            out_q <= 8'h00;
            out_sel_q <= 1'b0;
            was_sel_q <= 1'b0;
            boundary_q <= 1'b1;
            so_q <= 1'b0;
            so_oe_q <= 1'b0;
            op_start_q <= 1'b0;
            op_kind_q <= 2'h0;
            op_addr_q <= 24'h000000;
            op_suspend_q <= 1'b0;
            write_enable_latch_q <= 1'b0;
            rd_req_q <= 1'b0;
            rd_addr_q <= 24'h000000;
            fifo_push_q <= 1'b0;
            fifo_byte_q <= 8'h00;
            fifo_flush_q <= 1'b0;
            pgm_valid_q <= 1'b0;
            pgm_data_q <= 8'h00;
        end else begin
            was_sel_q <= selected;
            op_start_q <= 1'b0;
            op_suspend_q <= 1'b0;
            rd_req_q <= 1'b0;
            fifo_push_q <= 1'b0;
            fifo_flush_q <= 1'b0;
            // refill when empty or being taken; valid never waits on ready
            if (!pgm_valid_q || pgm_ready) begin
                pgm_valid_q <= fifo_out_valid;
                if (fifo_out_valid)
                    pgm_data_q <= fifo_out_data;
            end
            if (!selected) begin
                so_oe_q <= 1'b0;
                if (was_sel_q) begin
                    // deselect: commit write-type commands only on a byte boundary
                    if (boundary_q && st_q == ST_TAIL) begin
                        case (op_q)
                            `SFCD_OP_WRITE_ENABLE: write_enable_latch_q <= 1'b1;
                            `SFCD_OP_WRITE_DISABLE: write_enable_latch_q <= 1'b0;
                            `SFCD_OP_SUSPEND_A, `SFCD_OP_SUSPEND_B: begin
                                if (array_busy) begin
                                    op_suspend_q <= 1'b1;
                                    write_enable_latch_q <= 1'b0;
                                end
                            end
                            `SFCD_OP_SECTOR_ERASE: begin
                                if (write_enable_latch_q && !array_busy) begin
                                    op_start_q <= 1'b1;
                                    op_kind_q <= `SFCD_KIND_SECTOR;
                                    op_addr_q <= addr_q & `SFCD_SECTOR_MASK;
                                    write_enable_latch_q <= 1'b0;
                                end
                            end
                            `SFCD_OP_BLOCK_ERASE: begin
                                if (write_enable_latch_q && !array_busy) begin
                                    op_start_q <= 1'b1;
                                    op_kind_q <= `SFCD_KIND_BLOCK;
                                    op_addr_q <= addr_q & `SFCD_BLOCK_MASK;
                                    write_enable_latch_q <= 1'b0;
                                end
                            end
                            default: ;
                        endcase
                    end else if (boundary_q && st_q == ST_DATA_IN &&
                                 write_enable_latch_q && !array_busy) begin
                        op_start_q <= 1'b1;
                        op_kind_q <= `SFCD_KIND_PROGRAM;
                        op_addr_q <= addr_q & `SFCD_PAGE_MASK;
                        write_enable_latch_q <= 1'b0;
                    end else if (st_q == ST_DATA_IN)
                        fifo_flush_q <= 1'b1;
                end
                st_q <= ST_OP;
                bit_q <= 3'h0;
                abyte_q <= 2'h0;
                boundary_q <= 1'b1;
                out_sel_q <= 1'b0;
            end else if (sck_rise) begin
                sh_q <= sh_next;
                bit_q <= bit_q + 3'h1;
                boundary_q <= (bit_q == 3'h7);
                case (st_q)
                    ST_OP: begin
                        if (bit_q == 3'h7) begin
                            op_q <= sh_next;
                            if (is_addr_op(sh_next)) begin
                                st_q <= ST_ADDR;
                                if (sh_next == `SFCD_OP_PAGE_PROGRAM)
                                    fifo_flush_q <= 1'b1;
                            end else if (sh_next == `SFCD_OP_STATUS_READ) begin
                                out_q <= status_bits;
                                st_q <= ST_DATA_OUT;
                            end else if (sh_next == `SFCD_OP_CONFIG_READ) begin
                                out_q <= config1;
                                out_sel_q <= 1'b0;
                                st_q <= ST_DATA_OUT;
                            end else if (sh_next == `SFCD_OP_WRITE_ENABLE ||
                                         sh_next == `SFCD_OP_WRITE_DISABLE ||
                                         sh_next == `SFCD_OP_SUSPEND_A ||
                                         sh_next == `SFCD_OP_SUSPEND_B)
                                st_q <= ST_TAIL;
                            else
                                st_q <= ST_IGNORE;
                        end
                    end
                    ST_ADDR: begin
                        if (bit_q == 3'h7) begin
                            addr_q <= {addr_q[15:0], sh_next};
                            abyte_q <= abyte_q + 2'h1;
                            if (abyte_q == 2'h2) begin
                                if (op_q == `SFCD_OP_FAST_READ) begin
                                    st_q <= ST_DUMMY;
                                    dcnt_q <= 8'h00;
                                end else if (op_q == `SFCD_OP_READ) begin
                                    st_q <= ST_DATA_OUT;
                                    rd_req_q <= 1'b1;
                                    rd_addr_q <= {addr_q[15:0], sh_next};
                                end else if (op_q == `SFCD_OP_PAGE_PROGRAM)
                                    st_q <= ST_DATA_IN;
                                else
                                    st_q <= ST_TAIL;
                            end
                        end
                    end
                    ST_DUMMY: begin
                        dcnt_q <= dcnt_q + 8'h01;
                        if (dcnt_q == DUMMY_BITS[7:0] - 8'h01) begin
                            st_q <= ST_DATA_OUT;
                            rd_req_q <= 1'b1;
                            rd_addr_q <= addr_q;
                        end
                    end
                    ST_DATA_OUT: begin
                        // register reads reload here; array reads fetch at the next fall
                        if (bit_q == 3'h7 && !is_read_op(op_q)) begin
                            if (op_q == `SFCD_OP_STATUS_READ)
                                out_q <= status_bits;
                            else begin
                                out_sel_q <= !out_sel_q;
                                out_q <= out_sel_q ? config1 : config2;
                            end
                        end
                    end
                    ST_DATA_IN: begin
                        if (bit_q == 3'h7 && fifo_in_ready) begin
                            fifo_push_q <= 1'b1;
                            fifo_byte_q <= sh_next;
                        end
                    end
                    ST_TAIL: st_q <= ST_IGNORE;
                    ST_IGNORE: ;
                    default: st_q <= ST_IGNORE;
                endcase
            end else if (sck_fall && st_q == ST_DATA_OUT) begin
                // drive msb first on falling edge
                so_oe_q <= 1'b1;
                if (bit_q == 3'h0 && is_read_op(op_q)) begin
                    // fetch at byte start so the first streamed byte is the addressed one
                    so_q <= rd_data[7];
                    out_q <= rd_data;
                    rd_req_q <= 1'b1;
                    rd_addr_q <= rd_addr_q + 24'h000001;
                end else
                    so_q <= out_q[~bit_q];
            end
        end
    end
endmodule // sfcd_decoder

// file: sim/sfcd_decoder_sva.sv
// port checker for the serial flash command decoder
// assumes decoder clock domain, srst synchronous active high
`timescale 1ns/1ps
module sfcd_decoder_sva (
    // system
    input wire clock,
    input wire srst,
    // serial link
    input wire sclk,
    input wire cs_n,
    input wire so_q,
    input wire so_oe_q,
    // array side
    input wire array_busy,
    input wire op_start_q,
    input wire [1:0] op_kind_q,
    input wire [23:0] op_addr_q,
    input wire op_suspend_q,
    input wire write_enable_latch_q
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (srst);
    // long enough for the synchronisers to see the deselect
    sequence idle_s;
        cs_n [*6];
    endsequence
    sequence once_s;
        op_kind_q != 2'h3 ##1 !op_start_q;
    endsequence
    chk_page_align: assert property (op_start_q && op_kind_q == 2'h0 |->
        op_addr_q[7:0] == 8'h00) else $error("page launch not page aligned");
    chk_sector_align: assert property (op_start_q && op_kind_q == 2'h1 |->
        op_addr_q[11:0] == 12'h000) else $error("sector launch not aligned");
    chk_block_align: assert property (op_start_q && op_kind_q == 2'h2 |->
        op_addr_q[15:0] == 16'h0000) else $error("block launch not aligned");
    chk_launch_once: assert property (op_start_q |-> once_s)
        else $error("launch pulse too long or bad kind");
    chk_launch_latch: assert property (op_start_q |->
        $past(write_enable_latch_q) && !write_enable_latch_q) else $error("launch without latch");
    chk_launch_deselect: assert property (op_start_q |-> $past(cs_n, 2) && cs_n)
        else $error("launch before deselect");
    chk_suspend_busy: assert property (op_suspend_q |->
        $past(array_busy) && !write_enable_latch_q) else $error("bad suspend pulse");
    chk_so_idle: assert property (idle_s |-> !so_oe_q)
        else $error("output driven while deselected");
    chk_so_edge: assert property ($past(so_oe_q) && so_oe_q && $changed(so_q) |-> !sclk)
        else $error("output changed while serial clock high");
    chk_latch_frame: assert property ($changed(write_enable_latch_q) |-> cs_n)
        else $error("latch changed inside a frame");
endmodule // sfcd_decoder_sva

bind sfcd_decoder sfcd_decoder_sva chk_inst (
    .clock(clock), .srst(srst), .sclk(sclk), .cs_n(cs_n), .so_q(so_q),
    .so_oe_q(so_oe_q), .array_busy(array_busy), .op_start_q(op_start_q),
    .op_kind_q(op_kind_q), .op_addr_q(op_addr_q), .op_suspend_q(op_suspend_q),
    .write_enable_latch_q(write_enable_latch_q)
);

// file: sim/sfcd_host_model.sv
// host serial controller model, mode 0, single data line
// assumes clock at 20 ns; 8 clocks per serial bit gives 160 ns
`timescale 1ns/1ps
module sfcd_host_model (
    // system
    input wire clock,
    // serial link
    output logic sclk,
    output logic cs_n,
    output logic si,
    input wire so
);
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        si = 1'b0;
    end
    task automatic half();
        repeat (4) @(negedge clock);
    endtask
    task automatic start();
        half();
        cs_n = 1'b0;
        half();
    endtask
    // top n bits of b go out msb first; r gathers so at each rise
    task automatic xbits(input logic [7:0] b, input int n, output logic [7:0] r);
        r = 8'h00;
        for (int i = 0; i < n; i++) begin
            sclk = 1'b0;
            si = b[7 - i];
            half();
            sclk = 1'b1;
            r = {r[6:0], so};
            half();
        end
    endtask
    task automatic stop();
        sclk = 1'b0;
        half();
        cs_n = 1'b1;
        // released line must not keep showing the last bit
        si = ~si;
    endtask
endmodule // sfcd_host_model

// file: sim/testbench.sv
// self-checking bench for the serial flash command decoder
// assumes host model drives the link; bench plays the array side
`timescale 1ns/1ps
module testbench;
    logic clock, srst, array_busy, pgm_ready;
    logic [7:0] status_bits, config1, config2, rd_data, r;
    wire sclk, cs_n, si, so_q, so_oe_q, op_start_q, op_suspend_q;
    wire write_enable_latch_q, rd_req_q, pgm_valid_q;
    wire [1:0] op_kind_q;
    wire [23:0] op_addr_q, rd_addr_q;
    wire [7:0] pgm_data_q;
    int n_fail, num_checks, n_start, n_susp, n0;
    logic [1:0] kind_s;
    logic [23:0] addr_s;
    logic [7:0] pq[$];
    logic [7:0] ops[3] = '{8'h02, 8'h20, 8'hd8};
    logic [23:0] masks[3] = '{24'hffff00, 24'hfff000, 24'hff0000};

    sfcd_decoder #(.DUMMY_BITS(8)) sfcd_decoder_inst (
        .clock(clock), .srst(srst), .sclk(sclk), .cs_n(cs_n), .si(si), .so_q(so_q),
        .so_oe_q(so_oe_q), .array_busy(array_busy), .status_bits(status_bits),
        .config1(config1), .config2(config2), .op_start_q(op_start_q),
        .op_kind_q(op_kind_q), .op_addr_q(op_addr_q), .op_suspend_q(op_suspend_q),
        .write_enable_latch_q(write_enable_latch_q), .rd_req_q(rd_req_q),
        .rd_addr_q(rd_addr_q), .rd_data(rd_data), .pgm_valid_q(pgm_valid_q),
        .pgm_data_q(pgm_data_q), .pgm_ready(pgm_ready));
    sfcd_host_model sfcd_host_model_inst (
        .clock(clock), .sclk(sclk), .cs_n(cs_n), .si(si), .so(so_q));

    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end
    always @(posedge clock) begin
        if (op_start_q === 1'b1) begin
            n_start++;
            kind_s = op_kind_q;
            addr_s = op_addr_q;
        end
        if (op_suspend_q === 1'b1) n_susp++;
        if (pgm_valid_q === 1'b1 && pgm_ready === 1'b1) pq.push_back(pgm_data_q);
    end
    // array contents: address low byte scrambled
    always @(negedge clock) rd_data <= rd_addr_q[7:0] ^ 8'h3c;

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cmd(input logic [7:0] op);
        sfcd_host_model_inst.start();
        sfcd_host_model_inst.xbits(op, 8, r);
        sfcd_host_model_inst.stop();
        repeat (8) @(negedge clock);
    endtask
    task automatic afr(input logic [7:0] op, input logic [23:0] a, input int nd, input int tail);
        sfcd_host_model_inst.start();
        sfcd_host_model_inst.xbits(op, 8, r);
        for (int i = 0; i < 3; i++) sfcd_host_model_inst.xbits(a[23 - 8 * i -: 8], 8, r);
        for (int i = 0; i < nd; i++) sfcd_host_model_inst.xbits(8'h10 + 8'(i), 8, r);
        if (tail > 0) sfcd_host_model_inst.xbits(8'hff, tail, r);
        sfcd_host_model_inst.stop();
        repeat (8) @(negedge clock);
    endtask
    task automatic t_latch();
        cmd(8'h06);
        chk(write_enable_latch_q, 1);
        cmd(8'h04);
        chk(write_enable_latch_q, 0);
        n0 = n_start;
        afr(8'h20, 24'h123456, 0, 0);
        chk(n_start, n0);
    endtask
    task automatic t_ops();
        for (int i = 0; i < 3; i++) begin
            cmd(8'h06);
            n0 = n_start;
            afr(ops[i], 24'h3a5b7c, 0, 0);
            chk(n_start, n0 + 1);
            chk(kind_s, i);
            chk(addr_s, 24'h3a5b7c & masks[i]);
            chk(write_enable_latch_q, 0);
        end
    endtask
    task automatic t_boundary();
        cmd(8'h06);
        n0 = n_start;
        afr(8'h20, 24'h00f123, 0, 3);
        chk(n_start, n0);
        chk(write_enable_latch_q, 1);
        cmd(8'h04);
    endtask
    // sink stalls past the fifo depth, then drains it empty
    task automatic t_fifo();
        pgm_ready = 1'b0;
        pq.delete();
        cmd(8'h06);
        afr(8'h02, 24'h0456ab, 10, 0);
        chk(pgm_valid_q, 1);
        pgm_ready = 1'b1;
        repeat (30) @(negedge clock);
        // eight bytes in the fifo plus one in the output stage
        chk(pq.size(), 9);
        for (int i = 0; i < 9; i++) chk(pq[i], 8'h10 + 8'(i));
        chk(pgm_valid_q, 0);
    endtask
    task automatic t_suspend();
        array_busy = 1'b1;
        for (int i = 0; i < 2; i++) begin
            cmd(8'h06);
            n0 = n_susp;
            cmd(i == 0 ? 8'h75 : 8'hb0);
            chk(n_susp, n0 + 1);
            chk(write_enable_latch_q, 0);
        end
        array_busy = 1'b0;
        cmd(8'h75);
        chk(n_susp, n0 + 1);
    endtask
    task automatic t_regread();
        status_bits = 8'ha5;
        config1 = 8'h3c;
        config2 = 8'hc3;
        sfcd_host_model_inst.start();
        sfcd_host_model_inst.xbits(8'h05, 8, r);
        sfcd_host_model_inst.xbits(8'h00, 8, r);
        chk(r, 8'ha5);
        chk(so_oe_q, 1);
        sfcd_host_model_inst.stop();
        sfcd_host_model_inst.start();
        sfcd_host_model_inst.xbits(8'h15, 8, r);
        for (int i = 0; i < 3; i++) begin
            sfcd_host_model_inst.xbits(8'h00, 8, r);
            chk(r, i == 1 ? 8'hc3 : 8'h3c);
        end
        sfcd_host_model_inst.stop();
    endtask
    task automatic t_read();
        for (int j = 0; j < 2; j++) begin
            sfcd_host_model_inst.start();
            sfcd_host_model_inst.xbits(j == 0 ? 8'h03 : 8'h0b, 8, r);
            for (int i = 0; i < 3; i++) sfcd_host_model_inst.xbits(i == 2 ? 8'hfe : 8'h00, 8, r);
            if (j == 1) sfcd_host_model_inst.xbits(8'h00, 8, r);
            for (int k = 0; k < 3; k++) begin
                sfcd_host_model_inst.xbits(8'h00, 8, r);
                chk(r, 8'(8'hfe + k) ^ 8'h3c);
            end
            sfcd_host_model_inst.stop();
        end
    endtask
    task automatic complete_run();
        if (n_fail == 0 && num_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        #1000000;
        n_fail++;
        $display("[ERR] %0t watchdog expired", $time);
        complete_run();
    end
    initial begin
        {srst, array_busy, pgm_ready} = 3'b101;
        {status_bits, config1, config2} = 24'h0;
        repeat (5) @(negedge clock);
        srst = 1'b0;
        repeat (8) @(negedge clock);
        t_latch();
        t_ops();
        t_boundary();
        t_fifo();
        t_suspend();
        t_regread();
        t_read();
        complete_run();
    end
endmodule // testbench
